// file: rtl/sme_ctrl.sv
// serial memory command controller: registers, command sequencer, reload
`timescale 1ns/1ps
module sme_ctrl #(
    parameter int TIMEOUT_CYCLES = sme_pkg::TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic mem_cs,
    output logic mem_sck,
    input wire logic serial_mem_data_pin_lvl,
    output logic serial_mem_data_pin_drv,
    output logic serial_mem_data_pin_oe,
    output logic [47:0] station_addr
);
    import sme_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_GAP = 4'b0100,
        ST_POLL = 4'b1000
    } sme_state_t;

    typedef struct packed {
        sme_state_t st;
        logic pup;
        logic busy;
        logic [2:0] cmd;
        logic to;
        logic loaded;
        logic [7:0] addr;
        logic [7:0] data;
        logic [31:0] rdata;
        logic cs;
        logic start;
        logic [4:0] nbits;
        logic [4:0] ndrive;
        logic [18:0] tx;
        logic [TW-1:0] tmo;
        logic [2:0] idx;
        logic [5:0][7:0] mac;
    } sme_ctrl_st_t;

    sme_ctrl_st_t q, d;
    logic sh_done;
    logic [7:0] sh_rx;
    logic to_set;

    // start bit, opcode, byte address, data byte
    function automatic logic [18:0] sme_frame(input logic [2:0] c, input logic [7:0] a,
                                              input logic [7:0] dt);
        logic [18:0] f;
        f = {1'b1, OP_READ, a, 8'h00};
        case (c)
            CMD_WRITE: f = {1'b1, OP_WRITE, a, dt};
            CMD_ERASE: f = {1'b1, OP_ERASE, a, 8'h00};
            CMD_WRITE_EVERY: f = {1'b1, OP_MISC, PFX_WRITE_EVERY, 6'h00, dt};
            CMD_ERASE_EVERY: f = {1'b1, OP_MISC, PFX_ERASE_EVERY, 6'h00, 8'h00};
            CMD_PROG_UNLOCK: f = {1'b1, OP_MISC, PFX_PROG_UNLOCK, 6'h00, 8'h00};
            CMD_PROG_LOCK: f = {1'b1, OP_MISC, PFX_PROG_LOCK, 6'h00, 8'h00};
            default: f = {1'b1, OP_READ, a, 8'h00};
        endcase
        return f;
    endfunction

    function automatic logic is_prog(input logic [2:0] c);
        return (c == CMD_WRITE) || (c == CMD_WRITE_EVERY) || (c == CMD_ERASE)
               || (c == CMD_ERASE_EVERY);
    endfunction

    always_comb begin
        logic go;
        logic [2:0] lc;
        logic [7:0] la;
        logic launch;
        go = 1'b0;
        launch = 1'b0;
        lc = CMD_READ;
        la = ADDR_RST;
        to_set = 1'b0;
        d = q;
        d.start = 1'b0;
        d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                REG_CMD_OFF: d.rdata = {q.busy, q.cmd, 18'h00000, q.to, q.loaded, q.addr};
                REG_DATA_OFF: d.rdata = {24'h000000, q.data};
                default: d.rdata = '0;
            endcase
        end
        if (reg_wr && reg_addr == REG_CMD_OFF) begin
            if (reg_wdata[TO_BIT]) begin
                d.to = 1'b0;
            end
            if (reg_wdata[LOADED_BIT]) begin
                d.loaded = 1'b0;
            end
            // command and address are frozen while a command runs
            if (!q.busy) begin
                d.cmd = reg_wdata[CODE_HI:CODE_LO];
                d.addr = reg_wdata[ADDR_HI:0];
                go = reg_wdata[BUSY_BIT];
            end
        end
        if (reg_wr && reg_addr == REG_DATA_OFF && !q.busy) begin
            d.data = reg_wdata[7:0];
        end
        case (q.st)
            ST_IDLE: begin
                if (!q.pup) begin
                    d.pup = 1'b1;
                    d.busy = 1'b1;
                    d.cmd = CMD_RELOAD;
                    d.idx = 3'h0;
                    launch = 1'b1;
                    lc = CMD_READ;
                    la = ADDR_RST;
                end else if (go) begin
                    d.busy = 1'b1;
                    d.idx = 3'h0;
                    launch = 1'b1;
                    lc = (d.cmd == CMD_RELOAD) ? CMD_READ : d.cmd;
                    la = (d.cmd == CMD_RELOAD) ? ADDR_RST : d.addr;
                end
            end
            ST_SHIFT: begin
                if (sh_done) begin
                    d.cs = 1'b0;
                    d.tmo = '0;
                    d.st = ST_IDLE;
                    d.busy = 1'b0;
                    if (q.cmd == CMD_READ) begin
                        d.data = sh_rx;
                    end else if (q.cmd == CMD_RELOAD) begin
                        if (q.idx == 3'h0) begin
                            if (sh_rx == LOAD_SIG) begin
                                d.idx = 3'h1;
                                d.st = ST_GAP;
                                d.busy = 1'b1;
                            end
                        end else begin
                            d.mac[q.idx - 3'h1] = sh_rx;
                            if (q.idx == 3'(MAC_BYTES)) begin
                                d.loaded = 1'b1;
                            end else begin
                                d.idx = q.idx + 3'h1;
                                d.st = ST_GAP;
                                d.busy = 1'b1;
                            end
                        end
                    end else if (is_prog(q.cmd)) begin
                        d.st = ST_GAP;
                        d.busy = 1'b1;
                    end
                end
            end
            ST_GAP: begin
                // chip select must drop between frames before status polling
                if (q.tmo == TW'(CS_LOW_CYC - 1)) begin
                    d.tmo = '0;
                    if (q.cmd == CMD_RELOAD) begin
                        launch = 1'b1;
                        lc = CMD_READ;
                        la = {5'h00, q.idx};
                    end else begin
                        d.cs = 1'b1;
                        d.st = ST_POLL;
                    end
                end else begin
                    d.tmo = q.tmo + 1'b1;
                end
            end
            ST_POLL: begin
                if (serial_mem_data_pin_lvl) begin
                    d.cs = 1'b0;
                    d.busy = 1'b0;
                    d.st = ST_IDLE;
                end else if (q.tmo == TW'(TIMEOUT_CYCLES - 1)) begin
                    d.cs = 1'b0;
                    d.to = 1'b1;
                    to_set = 1'b1;
                    d.busy = 1'b0;
                    d.st = ST_IDLE;
                end else begin
                    d.tmo = q.tmo + 1'b1;
                end
            end
            default: begin
                d.st = ST_IDLE;
                d.busy = 1'b0;
                d.cs = 1'b0;
            end
        endcase
        if (launch) begin
            d.tx = sme_frame(lc, la, d.data);
            d.nbits = (lc == CMD_WRITE || lc == CMD_WRITE_EVERY || lc == CMD_READ)
                      ? FULL_BITS : HDR_BITS;
            d.ndrive = (lc == CMD_WRITE || lc == CMD_WRITE_EVERY) ? FULL_BITS : HDR_BITS;
            d.start = 1'b1;
            d.cs = 1'b1;
            d.st = ST_SHIFT;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.addr <= ADDR_RST;
            q.data <= DATA_RST;
        end else begin
            q <= d;
        end
    end

    sme_shift #(.HALF(SCK_HALF_CYC)) u_shift (
        .clk(clk),
        .resetn(resetn),
        .start(q.start),
        .nbits(q.nbits),
        .ndrive(q.ndrive),
        .tx(q.tx),
        .din(serial_mem_data_pin_lvl),
        .sck(mem_sck),
        .dout(serial_mem_data_pin_drv),
        .oe(serial_mem_data_pin_oe),
        .rx(sh_rx),
        .done(sh_done)
    );

    assign reg_rdata = q.rdata;
    assign mem_cs = q.cs;
    assign station_addr = q.mac;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_poll_expire;
        q.st == ST_POLL && !serial_mem_data_pin_lvl && q.tmo == TW'(TIMEOUT_CYCLES - 1);
    endsequence

    sequence s_reload_end;
        q.st == ST_SHIFT && sh_done && q.cmd == CMD_RELOAD && q.idx == 3'(MAC_BYTES);
    endsequence

    a_timeout_flag_set: assert property (s_poll_expire |=> q.to)
        else $error("timeout flag not set on expiry");
    a_timeout_to_idle: assert property (s_poll_expire |=> q.st == ST_IDLE && !q.busy && !q.cs)
        else $error("controller not idle after timeout");
    a_pin_high_done: assert property ((q.st == ST_POLL && serial_mem_data_pin_lvl)
        |=> q.st == ST_IDLE && !q.busy && !$rose(q.to))
        else $error("busy not cleared with data pin high");
    a_nonprog_no_tmo: assert property ((q.busy && !is_prog(q.cmd)) |=> !$rose(q.to))
        else $error("non-program command timed out");
    a_loaded_flag_set: assert property (s_reload_end |=> q.loaded && !q.busy)
        else $error("loaded flag not set after reload");
    a_addr_in_frame: assert property ((q.start && (q.cmd == CMD_READ || q.cmd == CMD_WRITE))
        |-> q.tx[15:8] == q.addr)
        else $error("frame address differs from address field");
    a_erase_frame_ok: assert property ((q.start && q.cmd == CMD_ERASE)
        |-> q.tx[17:16] == OP_ERASE && q.tx[15:8] == q.addr && q.nbits == HDR_BITS)
        else $error("erase frame malformed");
    a_read_data_held: assert property ((q.st == ST_SHIFT && sh_done && q.cmd == CMD_READ)
        |=> q.data == $past(sh_rx))
        else $error("read byte not captured");
    a_w1c_clears: assert property ((reg_wr && reg_addr == REG_CMD_OFF && reg_wdata[TO_BIT]
        && !to_set) |=> !q.to)
        else $error("timeout flag not cleared by write one");
endmodule

// file: rtl/sme_pkg.sv
// constants shared by the serial memory command controller
//
// Function
// - unanswered operation abandoned after 30 ms
// - timeout flag bit 9 set, resets 0
// - after timeout, back to idle
// - data pin high: no timeout, busy clears
// - data pin low: only program commands time out
// - address-loaded bit 8 set on valid load
// - 8-bit address field bits 7-0, resets zero
// - address field is byte granular
// - erase clears location chosen by address
// - data register bits 7:0, resets zero
package sme_pkg;
    localparam logic [7:0] REG_CMD_OFF = 8'hb0;
    localparam logic [7:0] REG_DATA_OFF = 8'hb4;
    localparam int BUSY_BIT = 31;
    localparam int CODE_HI = 30;
    localparam int CODE_LO = 28;
    localparam int TO_BIT = 9;
    localparam int LOADED_BIT = 8;
    localparam int ADDR_HI = 7;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_PROG_LOCK = 3'h1;
    localparam logic [2:0] CMD_PROG_UNLOCK = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_WRITE_EVERY = 3'h4;
    localparam logic [2:0] CMD_ERASE = 3'h5;
    localparam logic [2:0] CMD_ERASE_EVERY = 3'h6;
    localparam logic [2:0] CMD_RELOAD = 3'h7;

    localparam logic [1:0] OP_MISC = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] PFX_PROG_LOCK = 2'h0;
    localparam logic [1:0] PFX_WRITE_EVERY = 2'h1;
    localparam logic [1:0] PFX_ERASE_EVERY = 2'h2;
    localparam logic [1:0] PFX_PROG_UNLOCK = 2'h3;

    localparam logic [4:0] HDR_BITS = 5'h0b;
    localparam logic [4:0] FULL_BITS = 5'h13;
    localparam logic [7:0] LOAD_SIG = 8'ha5;
    localparam int MAC_BYTES = 6;

    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CS_LOW_NS = 250;
    localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS = 500;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: rtl/sme_shift.sv
// serial shifter for the memory frame: msb first, samples on rising clock
`timescale 1ns/1ps
module sme_shift #(
    parameter int HALF = sme_pkg::SCK_HALF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [4:0] nbits,
    input wire logic [4:0] ndrive,
    input wire logic [18:0] tx,
    input wire logic din,
    output logic sck,
    output logic dout,
    output logic oe,
    output logic [7:0] rx,
    output logic done
);
    import sme_pkg::*;

    typedef struct packed {
        logic busy;
        logic sck;
        logic dout;
        logic oe;
        logic done;
        logic [7:0] div;
        logic [4:0] left;
        logic [4:0] drv;
        logic [18:0] sh;
        logic [7:0] rx;
    } sme_shift_st_t;

    sme_shift_st_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (!q.busy) begin
            if (start) begin
                d.busy = 1'b1;
                d.sh = tx;
                d.left = nbits;
                d.drv = ndrive;
                d.dout = tx[18];
                d.oe = (ndrive != 5'h00);
                d.div = 8'h00;
                d.sck = 1'b0;
            end
        end else if (q.div == 8'(HALF - 1)) begin
            d.div = 8'h00;
            if (!q.sck) begin
                d.sck = 1'b1;
                d.rx = {q.rx[6:0], din};
            end else begin
                d.sck = 1'b0;
                d.left = q.left - 5'h01;
                d.sh = {q.sh[17:0], 1'b0};
                d.drv = (q.drv != 5'h00) ? q.drv - 5'h01 : 5'h00;
                if (q.left == 5'h01) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.oe = 1'b0;
                    d.dout = 1'b0;
                end else begin
                    d.dout = q.sh[17];
                    // release the pin once the memory starts answering
                    d.oe = (q.drv > 5'h01);
                end
            end
        end else begin
            d.div = q.div + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sck = q.sck;
    assign dout = q.dout;
    assign oe = q.oe;
    assign rx = q.rx;
    assign done = q.done;
endmodule

// file: test/sme_mem_model.sv
// behavioural serial memory standing on the controller's far side
`timescale 1ns/1ps
module sme_mem_model (
    input wire logic clk,
    input wire logic cs,
    input wire logic sck,
    input wire logic din,
    input wire logic fitted,
    input wire logic slow,
    output logic dout,
    output logic doe
);
    logic [7:0] mem [256];
    logic [18:0] sh;
    logic [4:0] nb;
    logic [7:0] rb;
    logic sck_q, cs_q, en, poll, fdrv, fd;
    int bsy;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        mem[0] = 8'ha5;
        for (int k = 1; k < 7; k++) mem[k] = 8'h10 + 8'(k);
        en = 1'b0; // write protected at power-up
        {sh, nb, rb, sck_q, cs_q, poll, fdrv, fd} = '0;
        bsy = 0;
    end
    // slow mode outlasts the controller's patience on purpose
    task automatic prog;
        poll <= 1'b1;
        bsy <= en ? (slow ? 200 : 10) : 0;
    endtask
    always @(posedge clk) begin
        sck_q <= sck;
        cs_q <= cs;
        if (bsy > 0) bsy <= bsy - 1;
        if (!cs) begin
            nb <= 5'h00;
            fdrv <= 1'b0;
        end else if (sck && !sck_q) begin
            sh <= {sh[17:0], din};
            nb <= nb + 5'h01;
        end else if (!sck && sck_q && nb == 5'h0b && sh[9:8] == 2'h2) begin
            rb <= mem[sh[7:0]];
            fd <= mem[sh[7:0]][7];
            fdrv <= 1'b1;
        end else if (!sck && sck_q && fdrv) begin
            if (nb < 5'h13) fd <= rb[5'h12 - nb];
            else fdrv <= 1'b0;
        end
        if (cs_q && !cs) begin
            if (poll && nb == 5'h00) begin
                poll <= 1'b0;
            end else if (nb == 5'h0b && sh[9:8] == 2'h3) begin
                if (en) mem[sh[7:0]] = 8'hff;
                prog();
            end else if (nb == 5'h0b && sh[9:8] == 2'h0) begin
                if (sh[7:6] == 2'h0) en <= 1'b0;
                if (sh[7:6] == 2'h3) en <= 1'b1;
                if (sh[7:6] == 2'h2) begin
                    if (en) for (int i = 0; i < 256; i++) mem[i] = 8'hff;
                    prog();
                end
            end else if (nb == 5'h13 && sh[17:16] == 2'h1) begin
                if (en) mem[sh[15:8]] = sh[7:0];
                prog();
            end else if (nb == 5'h13 && sh[17:14] == 4'h1) begin
                if (en) for (int i = 0; i < 256; i++) mem[i] = sh[7:0];
                prog();
            end
        end
    end
    assign doe = fitted && (fdrv || (poll && cs));
    assign dout = poll ? (bsy == 0) : fd;
endmodule

// file: test/serial_eeprom_command_controller_test.sv
// self-checking bench for the serial memory command controller
`timescale 1ns/1ps
module serial_eeprom_command_controller_test;
    import sme_pkg::*;
    typedef struct packed {
        logic [2:0] code;
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] edat;
    } sme_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pull = 1'b1;
    logic fitted = 1'b1;
    logic slow = 1'b0;
    logic [31:0] reg_rdata, v;
    logic mem_cs, mem_sck, pin_o, pin_oe, m_out, m_oe, wire_lvl;
    logic [47:0] station_addr;
    int n_fail = 0;
    int checked = 0;
    sme_row_t rows [16] = '{
        '{CMD_READ, 8'h03, 8'h00, 8'h13}, '{CMD_WRITE, 8'h20, 8'h5c, 8'h5c},
        '{CMD_READ, 8'h20, 8'h00, 8'h00}, '{3'h2, 8'h00, 8'h00, 8'h00},
        '{CMD_WRITE, 8'h20, 8'h5c, 8'h5c}, '{CMD_READ, 8'h20, 8'h00, 8'h5c},
        '{CMD_ERASE, 8'h20, 8'h00, 8'h00}, '{CMD_READ, 8'h20, 8'h00, 8'hff},
        '{CMD_READ, 8'h21, 8'h00, 8'h00}, '{3'h4, 8'h00, 8'h33, 8'h33},
        '{CMD_READ, 8'h90, 8'h00, 8'h33}, '{3'h6, 8'h00, 8'h00, 8'h00},
        '{CMD_READ, 8'h05, 8'h00, 8'hff}, '{3'h1, 8'h00, 8'h00, 8'h00},
        '{CMD_WRITE, 8'h40, 8'h11, 8'h11}, '{CMD_READ, 8'h40, 8'h00, 8'hff}};

    // the pull level wins only while nobody drives the pin
    assign wire_lvl = pin_oe ? pin_o : (m_oe ? m_out : pull);
    sme_ctrl #(.TIMEOUT_CYCLES(50)) dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cs(mem_cs),
        .mem_sck(mem_sck), .serial_mem_data_pin_lvl(wire_lvl),
        .serial_mem_data_pin_drv(pin_o),
        .serial_mem_data_pin_oe(pin_oe), .station_addr(station_addr));
    sme_mem_model u_mem (
        .clk(clk), .cs(mem_cs), .sck(mem_sck), .din(wire_lvl), .fitted(fitted),
        .slow(slow), .dout(m_out), .doe(m_oe));

    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_wide(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [7:0] a);
        wr(REG_CMD_OFF, {1'b1, c, 20'h0, a});
    endtask
    // bounded poll of the busy flag, leaves the last status in v
    task automatic wait_idle;
        for (int i = 0; i < 3000; i++) begin
            rd(REG_CMD_OFF, v);
            if (v[BUSY_BIT] === 1'b0) return;
        end
        chk(v & 32'h8000_0000, 32'h0);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        #1;
        chk_wide({mem_cs, pin_oe, station_addr[45:0]}, 48'h0);
        @(posedge clk);
        resetn <= 1'b1;
        wait_idle();
        chk(v & 32'h8000_03ff, 32'h0000_0100);
        chk_wide(station_addr, 48'h1615_1413_1211);
        rd(REG_DATA_OFF, v);
        chk(v, 32'h0);
        wr(REG_CMD_OFF, 32'h0);
        rd(REG_CMD_OFF, v);
        chk(v & 32'h300, 32'h100);
        wr(REG_CMD_OFF, 32'h100);
        rd(REG_CMD_OFF, v);
        chk(v & 32'h300, 32'h0);
        cmd(CMD_RELOAD, 8'h00);
        wait_idle();
        chk(v & 32'h8000_0300, 32'h100);
        foreach (rows[i]) begin
            wr(REG_DATA_OFF, {24'h0, rows[i].wdat});
            cmd(rows[i].code, rows[i].addr);
            wait_idle();
            chk(v & 32'h8000_02ff, {24'h0, rows[i].addr});
            rd(REG_DATA_OFF, v);
            chk(v, {24'h0, rows[i].edat});
        end
        // memory that answers too late must be abandoned
        cmd(3'h2, 8'h00);
        wait_idle();
        slow <= 1'b1;
        cmd(CMD_WRITE, 8'h50);
        wait_idle();
        chk(v & 32'h8000_02ff, 32'h0000_0250);
        wr(REG_CMD_OFF, 32'h0);
        rd(REG_CMD_OFF, v);
        chk(v & 32'h200, 32'h200);
        wr(REG_CMD_OFF, 32'h200);
        rd(REG_CMD_OFF, v);
        chk(v & 32'h200, 32'h0);
        slow <= 1'b0;
        cmd(CMD_READ, 8'h03);
        wait_idle();
        rd(REG_DATA_OFF, v);
        chk(v, 32'hff);
        fitted <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            pull <= 1'(p);
            for (int c = 0; c < 8; c++) begin
                cmd(3'(c), 8'h00);
                wait_idle();
                chk(v & 32'h8000_0200, {22'h0, (p == 0 && c >= 3 && c <= 6), 9'h0});
                wr(REG_CMD_OFF, 32'h0000_0200);
            end
        end
        wr(8'hb8, 32'hffff_ffff);
        rd(8'hb8, v);
        chk(v, 32'h0);
        wr(REG_DATA_OFF, 32'hffff_ffff);
        rd(REG_DATA_OFF, v);
        chk(v, 32'h0000_00ff);
        // reset in mid-frame must drop the link and rerun the load
        pull <= 1'b0;
        cmd(CMD_WRITE, 8'h12);
        repeat (30) @(posedge clk);
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk_wide({mem_cs, pin_oe, station_addr[45:0]}, 48'h0);
        @(posedge clk);
        resetn <= 1'b1;
        wait_idle();
        chk(v & 32'h8000_03ff, 32'h0);
        rd(REG_DATA_OFF, v);
        chk(v, 32'h0);
        chk_wide(station_addr, 48'h0);
        tally_and_finish();
    end
endmodule
